// [rtl/port_d_defines.svh]
// Register offsets, reset values and field positions of the port D control block
`ifndef PORT_D_DEFINES_SVH
`define PORT_D_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PORT_DATA_LATCH 12'h000
`define OFS_PIN_DIRECTION 12'h004
`define OFS_PULL_ENABLE 12'h008
`define OFS_SLEW_RATE_ENABLE 12'h00c
`define OFS_DRIVE_STRENGTH_SELECT 12'h010
`define OFS_PIN_IRQ_STATUS_CONTROL 12'h014
`define OFS_IRQ_PIN_SELECT 12'h018
`define OFS_EDGE_POLARITY_SELECT 12'h01c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_SLEW 8'h00

// ----------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------
`define SC_FLAG_BIT 3
`define SC_ACK_BIT 2
`define SC_IE_BIT 1
`define SC_MODE_BIT 0

`endif

// [rtl/port_d_pkg.sv]
// Types shared by the port D control block
package port_d_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_state_e;
endpackage : port_d_pkg

// [rtl/port_d_pin_control_irq.sv]
// AHB-Lite slave for one 8-bit port: direction, pulls, slew, drive and pin interrupt
`timescale 1ns/100ps
`include "port_d_defines.svh"

// Notes on behaviour
// - Direction 0: driver off, read pin level
// - Direction 1: driver on, read latch
// - Pull enable bit turns pull on
// - Output pins never get a pull
// - Pull-down only for interrupt pin, rising select
// - Slew bit acts only on output pins
// - Drive strength bit acts only on outputs
// - Flag bit 3 set on detect, writes ignored
// - Acknowledge bit 2 clears flag, reads 0
// - Enable bit 1 gates interrupt request
// - Mode bit 0: edges, or edges and levels
// - Unselected pins never raise the flag
// - Edge select 0 falling/low, 1 rising/high
// - Reset: latch zero, inputs, pulls off
module port_d_pin_control_irq
    import port_d_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_down_en,
    output logic [7:0] slew_en,
    output logic [7:0] drive_high,
    // Interrupt request to the core
    output logic irq_req
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bus_state_e bus_r, bus_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    byte_t port_data_latch_r, port_data_latch_nxt;
    byte_t pin_direction_r, pin_direction_nxt;
    byte_t pull_enable_r, pull_enable_nxt;
    byte_t slew_rate_enable_r, slew_rate_enable_nxt;
    byte_t drive_strength_select_r, drive_strength_select_nxt;
    byte_t irq_pin_select_r, irq_pin_select_nxt;
    byte_t edge_polarity_select_r, edge_polarity_select_nxt;
    logic pin_irq_flag_r, pin_irq_flag_nxt;
    logic pin_irq_enable_r, pin_irq_enable_nxt;
    logic detect_mode_select_r, detect_mode_select_nxt;
    byte_t pin_prev_r, pin_prev_nxt;
    byte_t pin_out_r, pin_oe_r, pull_up_r, pull_down_r, slew_r, drive_r;
    byte_t pin_out_nxt, pin_oe_nxt, pull_up_nxt, pull_down_nxt, slew_nxt, drive_nxt;
    logic irq_r, irq_nxt;

    // ----------------------------------------------------------------
    // Detection
    // ----------------------------------------------------------------
    byte_t active_lvl, prev_lvl, edge_hit, level_hit;
    logic detect, level_active, ack_wr;

    always_comb begin
        // Pins normalised so that 1 is the active level
        active_lvl = (pin_in ~^ edge_polarity_select_r) & irq_pin_select_r;
        prev_lvl = (pin_prev_r ~^ edge_polarity_select_r) & irq_pin_select_r;
        edge_hit = active_lvl & ~prev_lvl;
        level_hit = detect_mode_select_r ? active_lvl : 8'h00;
        level_active = |level_hit;
        detect = (|edge_hit) | level_active;
    end

    // ----------------------------------------------------------------
    // Bus and registers
    // ----------------------------------------------------------------
    byte_t wbyte, read_port;

    always_comb begin
        wbyte = hwdata[7:0];
        bus_nxt = BUS_IDLE;
        addr_nxt = addr_r;
        port_data_latch_nxt = port_data_latch_r;
        pin_direction_nxt = pin_direction_r;
        pull_enable_nxt = pull_enable_r;
        slew_rate_enable_nxt = slew_rate_enable_r;
        drive_strength_select_nxt = drive_strength_select_r;
        irq_pin_select_nxt = irq_pin_select_r;
        edge_polarity_select_nxt = edge_polarity_select_r;
        pin_irq_enable_nxt = pin_irq_enable_r;
        detect_mode_select_nxt = detect_mode_select_r;
        ack_wr = 1'b0;
        // Pin level per input pin, latch per output pin
        read_port = (pin_in & ~pin_direction_r) | (port_data_latch_r & pin_direction_r);
        case (bus_r)
            BUS_WRITE: begin
                case (addr_r)
                    `OFS_PORT_DATA_LATCH: port_data_latch_nxt = wbyte;
                    `OFS_PIN_DIRECTION: pin_direction_nxt = wbyte;
                    `OFS_PULL_ENABLE: pull_enable_nxt = wbyte;
                    `OFS_SLEW_RATE_ENABLE: slew_rate_enable_nxt = wbyte;
                    `OFS_DRIVE_STRENGTH_SELECT: drive_strength_select_nxt = wbyte;
                    `OFS_PIN_IRQ_STATUS_CONTROL: begin
                        ack_wr = wbyte[`SC_ACK_BIT];
                        pin_irq_enable_nxt = wbyte[`SC_IE_BIT];
                        detect_mode_select_nxt = wbyte[`SC_MODE_BIT];
                    end
                    `OFS_IRQ_PIN_SELECT: irq_pin_select_nxt = wbyte;
                    `OFS_EDGE_POLARITY_SELECT: edge_polarity_select_nxt = wbyte;
                    default: ack_wr = 1'b0;
                endcase
            end
            default: ack_wr = 1'b0;
        endcase
        // New address phase; read data is presented in the following data phase
        if (hsel && hready && htrans[1]) begin
            addr_nxt = {haddr[11:2], 2'b00};
            bus_nxt = hwrite ? BUS_WRITE : BUS_READ;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read word is produced one cycle early from the address phase; the _nxt
    // values let a read right behind a write see the word that write lands, except at the data offset, which reads the latch and direction flops
    byte_t early_rd;
    logic [11:0] a_now;
    logic rd_start;
    logic ready_r, ready_nxt;
    logic hresp_r, hresp_nxt;

    always_comb begin
        a_now = {haddr[11:2], 2'b00};
        rd_start = hsel && hready && htrans[1] && !hwrite;
        early_rd = 8'h00;
        case (a_now)
            `OFS_PORT_DATA_LATCH: early_rd = read_port;
            `OFS_PIN_DIRECTION: early_rd = pin_direction_nxt;
            `OFS_PULL_ENABLE: early_rd = pull_enable_nxt;
            `OFS_SLEW_RATE_ENABLE: early_rd = slew_rate_enable_nxt;
            `OFS_DRIVE_STRENGTH_SELECT: early_rd = drive_strength_select_nxt;
            `OFS_PIN_IRQ_STATUS_CONTROL: early_rd = {4'h0, pin_irq_flag_nxt, 1'b0,
                pin_irq_enable_nxt, detect_mode_select_nxt};
            `OFS_IRQ_PIN_SELECT: early_rd = irq_pin_select_nxt;
            `OFS_EDGE_POLARITY_SELECT: early_rd = edge_polarity_select_nxt;
            default: early_rd = 8'h00;
        endcase
        // Unmapped words and idle cycles read as zero
        hrdata_nxt = 32'h0000_0000;
        if (rd_start) begin
            hrdata_nxt = {24'h000000, early_rd};
        end
        // Zero wait states and an OKAY answer, each still held in a flop
        ready_nxt = 1'b1;
        hresp_nxt = 1'b0;
    end

    // ----------------------------------------------------------------
    // Flag and request
    // ----------------------------------------------------------------
    always_comb begin
        pin_prev_nxt = pin_in;
        pin_irq_flag_nxt = pin_irq_flag_r;
        // Set wins over an acknowledge in the same cycle
        if (ack_wr && !level_active) begin
            pin_irq_flag_nxt = 1'b0;
        end
        if (detect) begin
            pin_irq_flag_nxt = 1'b1;
        end
        irq_nxt = pin_irq_flag_nxt & pin_irq_enable_nxt;
    end

    // ----------------------------------------------------------------
    // Pad controls
    // ----------------------------------------------------------------
    // Pads follow the _nxt values so they change on the same edge as the register
    always_comb begin
        pin_out_nxt = port_data_latch_nxt;
        pin_oe_nxt = pin_direction_nxt;
        // Pull-down replaces pull-up only on selected interrupt pins with rising polarity
        pull_down_nxt = pull_enable_nxt & ~pin_direction_nxt & irq_pin_select_nxt
            & edge_polarity_select_nxt;
        pull_up_nxt = pull_enable_nxt & ~pin_direction_nxt & ~pull_down_nxt;
        slew_nxt = slew_rate_enable_nxt & pin_direction_nxt;
        drive_nxt = drive_strength_select_nxt & pin_direction_nxt;
    end

    // ----------------------------------------------------------------
    // Bus registers
    // ----------------------------------------------------------------
    // hreadyout resets high so a master may start on the first edge after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_r <= BUS_IDLE;
            addr_r <= 12'h000;
            hrdata_r <= 32'h0000_0000;
            ready_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            bus_r <= bus_nxt;
            addr_r <= addr_nxt;
            hrdata_r <= hrdata_nxt;
            ready_r <= ready_nxt;
            hresp_r <= hresp_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Slew bits reset to a fixed value, yet software is expected to set them anyway
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_data_latch_r <= `RST_BYTE;
            pin_direction_r <= `RST_BYTE;
            pull_enable_r <= `RST_BYTE;
            slew_rate_enable_r <= `RST_SLEW;
            drive_strength_select_r <= `RST_BYTE;
            irq_pin_select_r <= `RST_BYTE;
            edge_polarity_select_r <= `RST_BYTE;
            pin_irq_enable_r <= 1'b0;
            detect_mode_select_r <= 1'b0;
        end else begin
            port_data_latch_r <= port_data_latch_nxt;
            pin_direction_r <= pin_direction_nxt;
            pull_enable_r <= pull_enable_nxt;
            slew_rate_enable_r <= slew_rate_enable_nxt;
            drive_strength_select_r <= drive_strength_select_nxt;
            irq_pin_select_r <= irq_pin_select_nxt;
            edge_polarity_select_r <= edge_polarity_select_nxt;
            pin_irq_enable_r <= pin_irq_enable_nxt;
            detect_mode_select_r <= detect_mode_select_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt registers
    // ----------------------------------------------------------------
    // Previous sample resets low; no pin is selected at reset, so no pin sees an edge from it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_irq_flag_r <= 1'b0;
            pin_prev_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            pin_irq_flag_r <= pin_irq_flag_nxt;
            pin_prev_r <= pin_prev_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pad registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out_r <= 8'h00;
            pin_oe_r <= 8'h00;
            pull_up_r <= 8'h00;
            pull_down_r <= 8'h00;
            slew_r <= 8'h00;
            drive_r <= 8'h00;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            pull_up_r <= pull_up_nxt;
            pull_down_r <= pull_down_nxt;
            slew_r <= slew_nxt;
            drive_r <= drive_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every port below is a plain copy of a flop, so no glitch reaches the pads
    assign hrdata = hrdata_r;
    assign hreadyout = ready_r;
    assign hresp = hresp_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pull_up_en = pull_up_r;
    assign pull_down_en = pull_down_r;
    assign slew_en = slew_r;
    assign drive_high = drive_r;
    assign irq_req = irq_r;

endmodule : port_d_pin_control_irq

// [test/port_d_sva.sv]
// Port-level checker for the port D control block
`timescale 1ns/100ps
module port_d_sva
    import port_d_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    input wire logic [7:0] slew_en,
    input wire logic [7:0] drive_high,
    input wire logic irq_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic req;
    assign req = hsel && hready && htrans[1];
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    bus_okay_a: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h000000)
        else $error("bus answer not a zero-wait okay");
    out_no_pull_a: assert property (((pull_up_en | pull_down_en) & pin_oe) == 8'h00)
        else $error("pull active on an output pin");
    pull_exclusive_a: assert property ((pull_up_en & pull_down_en) == 8'h00)
        else $error("pull-up and pull-down together");
    slew_out_only_a: assert property ((slew_en & ~pin_oe) == 8'h00)
        else $error("slew control on an input pin");
    drive_out_only_a: assert property ((drive_high & ~pin_oe) == 8'h00)
        else $error("high drive on an input pin");
    reset_idle_a: assert property (!$past(hresetn) |-> (pin_oe | pin_out | pull_up_en) == 8'h00)
        else $error("pins not idle after reset");
    ack_reads_zero_a: assert property (req && !hwrite && haddr[11:2] == 10'd5 |=> !hrdata[2])
        else $error("acknowledge bit read back as one");
    data_read_a: assert property (req && !hwrite && haddr[11:2] == 10'd0 |=> hrdata[7:0] ==
        (($past(pin_oe) & $past(pin_out)) | (~$past(pin_oe) & $past(pin_in))))
        else $error("data read mixes latch and pins wrongly");
    // ----------------------------------------------------------------
    // Covers
    // ----------------------------------------------------------------
    rd_c: cover property (req && !hwrite);
    wr_c: cover property (req && hwrite);
    irq_c: cover property ($rose(irq_req));
    pd_c: cover property (pull_down_en != 8'h00);
endmodule : port_d_sva

bind port_d_pin_control_irq port_d_sva port_d_sva_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .slew_en(slew_en), .drive_high(drive_high), .irq_req(irq_req));

// [test/port_d_board.sv]
// Board model that settles the level seen on each port pin
`timescale 1ns/100ps
module port_d_board (
    // Clock
    input wire logic hclk,
    // Device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    // Board drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    // Undriven pins wander so a floating read never passes by luck
    logic [7:0] float_r = 8'h00;
    always_ff @(posedge hclk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pull_up_en[i]) pin_in[i] = 1'b1;
            else if (pull_down_en[i]) pin_in[i] = 1'b0;
            else pin_in[i] = float_r[i];
        end
    end
endmodule : port_d_board

// [test/port_d_pin_control_irq_tb_top.sv]
// Self-checking bench for the port D control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module port_d_pin_control_irq_tb_top
    import port_d_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata, rd;
    logic hready, hresp, irq_req;
    logic [7:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, slew_en, drive_high;
    logic [7:0] ext_val = 8'h5a;
    logic [7:0] ext_en = 8'hff;
    int err_total = 0, cmp_count = 0, flag = 0;
    int seed = 32'h4de2;
    byte_t m [8] = '{default: 8'h00};

    port_d_pin_control_irq port_d_pin_control_irq_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .slew_en(slew_en), .drive_high(drive_high),
        .irq_req(irq_req));
    port_d_board port_d_board_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    initial forever #25 hclk = ~hclk;

    // ----------------------------------------------------------------
    // Bus master and reference model
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_total++;
            summarize();
        end
    endtask : wait_rdy

    task automatic xfer(input logic w, input int a, input byte_t d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= 12'(a * 4);
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        wait_rdy();
        rd = hrdata;
    endtask : xfer

    task automatic wr(input int a, input byte_t d);
        xfer(1'b1, a, d);
        if (a < 8) m[a] = (a == 5) ? (d & 8'h03) : d;
    endtask : wr

    function automatic byte_t exp_rd(input int a);
        byte_t lvl;
        lvl = (ext_val & ext_en) | (m[2] & ~ext_en & ~(m[6] & m[7]));
        if (a == 0) return (m[0] & m[1]) | (lvl & ~m[1]);
        if (a == 5) return {4'h0, flag[0], 1'b0, m[5][1:0]};
        return (a < 8) ? m[a] : 8'h00;
    endfunction : exp_rd

    task automatic rdm(input int a, input string nm);
        xfer(1'b0, a, 8'h00);
        `CHK(nm, {24'h000000, exp_rd(a)}, rd)
    endtask : rdm

    task automatic pads();
        byte_t pd;
        @(posedge hclk);
        pd = m[2] & ~m[1] & m[6] & m[7];
        `CHK("pin_oe", m[1], pin_oe)
        `CHK("pin_out", m[0], pin_out)
        `CHK("pull_up", m[2] & ~m[1] & ~pd, pull_up_en)
        `CHK("pull_down", pd, pull_down_en)
        `CHK("slew", m[3] & m[1], slew_en)
        `CHK("drive", m[4] & m[1], drive_high)
        `CHK("irq_req", 1'(flag) & m[5][1], irq_req)
    endtask : pads

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 9; a++) rdm(a, "reset value");
        pads();
        wr(8, 8'hff);
        rdm(8, "unmapped");
        $display("test reset done");
        // Random setups with every pin left out of interrupt duty
        for (int i = 0; i < 20; i++) begin
            for (int a = 0; a < 5; a++) wr(a, 8'($random(seed)));
            wr(7, 8'($random(seed)));
            ext_val <= 8'($random(seed));
            for (int a = 0; a < 8; a++) rdm(a, "config");
            pads();
        end
        $display("test config done");
        wr(1, 8'h00);
        wr(2, 8'hff);
        wr(6, 8'h00);
        ext_en <= 8'h00;
        rdm(0, "pull up level");
        wr(7, 8'hf0);
        wr(6, 8'hff);
        rdm(0, "pull down level");
        pads();
        $display("test pull done");
        ext_en <= 8'hff;
        for (int p = 0; p < 2; p++) begin
            wr(6, 8'h00);
            ext_val <= 8'(1 - p);
            wr(7, 8'(p));
            wr(6, 8'h01);
            wr(5, 8'h06);
            flag = 0;
            rdm(5, "idle");
            ext_val <= 8'(p);
            repeat (3) @(posedge hclk);
            flag = 1;
            rdm(5, "edge");
            pads();
            wr(5, 8'h0a);
            rdm(5, "flag write");
            wr(5, 8'h06);
            flag = 0;
            rdm(5, "ack");
            pads();
        end
        wr(5, 8'h00);
        ext_val <= 8'h00;
        repeat (3) @(posedge hclk);
        ext_val <= 8'h01;
        repeat (3) @(posedge hclk);
        flag = 1;
        rdm(5, "masked");
        pads();
        $display("test edge done");
        wr(5, 8'h07);
        rdm(5, "level ack held");
        ext_val <= 8'h00;
        repeat (3) @(posedge hclk);
        wr(5, 8'h07);
        flag = 0;
        rdm(5, "level ack");
        pads();
        $display("test level done");
        summarize();
    end
endmodule : port_d_pin_control_irq_tb_top
